// file: tb_vin_uv_response_and_ramp_sequencer.sv
`timescale 1ns/10ps
module tb_vin_uv_response_and_ramp_sequencer;
    import vuvrs_pkg::*;
    localparam int TK = 4;
    localparam int MS = TK * TICK_PER_MS;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        en_pin = 1'b0;
    logic        operation_on = 1'b0;
    logic        vin_uv_fault = 1'b0;
    logic        other_fault = 1'b0;
    logic        multi_phase = 1'b0;
    logic [15:0] vout_meas = 16'h0000;
    logic [7:0]  pm_cmd;
    logic        pm_page, pm_wr, pm_rd, pm_ack, pm_nack;
    logic [15:0] pm_wdata, pm_rdata;
    logic        out_enable, ramp_active, power_good, alert_out_n;
    logic        uv_fault_flag;
    logic [15:0] mdl [int];
    logic [17:0] r;
    logic [7:0]  cl [4] = '{8'h5A, 8'h5E, 8'h60, 8'h61};
    int          fails = 0;
    int          tests_run = 0;
    int          n;
    bit   [31:0] seed = 32'h00011546;

    always #2.5 ref_clk = ~ref_clk;

    // Strap 1000 and output UV limit 800 keep the threshold above the limit
    vuvrs_top #(.TICK_CYCLES(TK)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .pm_cmd(pm_cmd),
        .pm_page(pm_page), .pm_wr(pm_wr), .pm_rd(pm_rd),
        .pm_wdata(pm_wdata), .pm_rdata(pm_rdata), .pm_ack(pm_ack),
        .pm_nack(pm_nack), .en_pin(en_pin), .operation_on(operation_on),
        .vin_uv_fault(vin_uv_fault), .other_fault(other_fault),
        .multi_phase(multi_phase), .output_setpoint_strap(16'h03E8),
        .vout_meas(vout_meas),
        .output_undervoltage_fault_threshold(16'h0320),
        .out_enable(out_enable), .ramp_active(ramp_active),
        .power_good(power_good), .alert_out_n(alert_out_n),
        .uv_fault_flag(uv_fault_flag));
    vuvrs_host host_u (
        .ref_clk(ref_clk), .pm_cmd(pm_cmd), .pm_page(pm_page),
        .pm_wr(pm_wr), .pm_rd(pm_rd), .pm_wdata(pm_wdata),
        .pm_rdata(pm_rdata), .pm_ack(pm_ack), .pm_nack(pm_nack));

    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    function automatic int key(logic [7:0] c, logic p);
        return c == 8'h5A ? 0 : {c, p};
    endfunction
    task automatic give_verdict();
        $display("Counts: %0d checks, %0d mismatches", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [15:0] e,
                       input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", s, e, g);
            fails++;
        end
    endtask
    task automatic rng(input string s, input int lo, input int hi);
        tests_run++;
        if (n < lo || n > hi) begin
            $display("Error %s expected %0d..%0d seen %0d", s, lo, hi, n);
            fails++;
        end
    endtask
    task automatic wl(input int sel, input logic lvl, input int lim);
        logic v;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
            v = sel == 0 ? out_enable : sel == 1 ? ramp_active : power_good;
        end while (v !== lvl && n < lim);
        if (v !== lvl) begin
            $display("Error wait %0d expected %b seen %b", sel, lvl, v);
            fails++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic p,
                      input logic [15:0] d);
        host_u.xfer(1'b1, c, p, d, r);
        chk("write ack", 16'h0002, {14'h0, r[17:16]});
        if (c != 8'h03)
            mdl[key(c, p)] = c == 8'h5A ? {8'h00, d[7:0]} : d;
    endtask
    task automatic rd(input logic [7:0] c, input logic p);
        logic hit;
        hit = mdl.exists(key(c, p));
        host_u.xfer(1'b0, c, p, 16'h0000, r);
        chk("read ack", hit ? 16'h0002 : 16'h0001, {14'h0, r[17:16]});
        chk("read data", hit ? mdl[key(c, p)] : 16'h0000, r[15:0]);
    endtask
    task automatic pulse();
        vin_uv_fault = 1'b1;
        repeat (2) @(negedge ref_clk);
        vin_uv_fault = 1'b0;
    endtask
    task automatic stay_off(input int cyc);
        int hi;
        hi = 0;
        repeat (3) @(negedge ref_clk);
        repeat (cyc) begin
            @(negedge ref_clk);
            hi += int'(out_enable === 1'b1);
        end
        chk("stays off", 16'h0000, 16'(hi));
    endtask

    initial begin
        mdl[0] = 16'h00BF;
        mdl[key(8'h5E, 1'b0)] = 16'h0384;
        mdl[key(8'h5E, 1'b1)] = 16'h0384;
        mdl[key(8'h60, 1'b0)] = 16'hD280;
        mdl[key(8'h60, 1'b1)] = 16'hCA80;
        mdl[key(8'h61, 1'b0)] = 16'hCA80;
        mdl[key(8'h61, 1'b1)] = 16'hCA80;
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        for (int i = 0; i < 8; i++)
            rd(cl[i/2], i[0]);
        rd(8'h03, 1'b0);
        rd(8'h10, 1'b1);
        for (int i = 0; i < 16; i++) begin
            wr(cl[i%4], 1'b1, rnd());
            rd(cl[i%4], 1'b1);
        end
        $display("test registers done");
        wr(8'h60, 1'b0, 16'h0801);
        wr(8'h61, 1'b0, 16'hF808);
        wr(8'h5A, 1'b0, 16'h00B8);
        en_pin = 1'b1;
        operation_on = 1'b1;
        wl(0, 1'b1, 400);
        rng("turn-on delay", 2*MS-TK-3, 2*MS+TK+4);
        chk("ramp", 16'h0001, {15'h0, ramp_active});
        wl(1, 1'b0, 600);
        rng("rise time", 4*MS-TK-3, 4*MS+TK+3);
        vout_meas = 16'h03E8;
        wl(2, 1'b1, 4);
        vout_meas = 16'h0352;
        repeat (8) @(negedge ref_clk);
        chk("pg band", 16'h0001, {15'h0, power_good});
        vout_meas = 16'h02BC;
        wl(2, 1'b0, 4);
        vout_meas = 16'h03E8;
        $display("test start-up done");
        for (int c = 0; c < 2; c++) begin
            wr(8'h5A, 1'b0, 16'h00B8 - 16'(c * 127));
            pulse();
            chk("alert", 16'h0000, {15'h0, alert_out_n});
            chk("out off", 16'h0000, {15'h0, out_enable});
            wl(0, 1'b1, 5000);
            pulse();
            wl(0, 1'b1, 5000);
            n += 2;
            rng("spacing", (c+1)*35*MS-TK-3,
                (c+1)*35*MS+TK+3);
        end
        chk("flag kept", 16'h0001, {15'h0, uv_fault_flag});
        wr(8'h03, 1'b0, 16'h0000);
        chk("flag clr", 16'h0002,
            {14'h0, alert_out_n, uv_fault_flag});
        $display("test retry done");
        wr(8'h5A, 1'b0, 16'h00C0);
        vin_uv_fault = 1'b1;
        stay_off(300);
        vin_uv_fault = 1'b0;
        wl(0, 1'b1, 400);
        rng("resume", 2*MS-TK-3, 2*MS+TK+4);
        wr(8'h5A, 1'b0, 16'h0080);
        pulse();
        stay_off(3000);
        en_pin = 1'b0;
        repeat (2) @(negedge ref_clk);
        en_pin = 1'b1;
        wl(0, 1'b1, 400);
        rng("restart", 2*MS-TK-3, 2*MS+TK+4);
        $display("test hold and latch done");
        wr(8'h5A, 1'b0, 16'h00BF);
        pulse();
        operation_on = 1'b0;
        repeat (4) @(negedge ref_clk);
        operation_on = 1'b1;
        multi_phase = 1'b1;
        wl(0, 1'b1, 400);
        rng("abandon", 2*MS-TK-3, 2*MS+TK+4);
        chk("no ramp", 16'h0000, {15'h0, ramp_active});
        other_fault = 1'b1;
        @(negedge ref_clk);
        other_fault = 1'b0;
        stay_off(600);
        $display("test abandon done");
        give_verdict();
    end
endmodule

// file: vuvrs_host.sv
`timescale 1ns/10ps
module vuvrs_host
    import vuvrs_pkg::*;
(
    input  wire logic        ref_clk,
    output logic      [7:0]  pm_cmd,
    output logic             pm_page,
    output logic             pm_wr,
    output logic             pm_rd,
    output logic      [15:0] pm_wdata,
    input  wire logic [15:0] pm_rdata,
    input  wire logic        pm_ack,
    input  wire logic        pm_nack
);
    initial begin
        pm_cmd   = 8'h00;
        pm_page  = 1'b0;
        pm_wr    = 1'b0;
        pm_rd    = 1'b0;
        pm_wdata = 16'h0000;
    end
    // One-cycle strobe; afterwards command and data lines carry the inverse value
    task automatic xfer(input logic w, input logic [7:0] c,
        input logic p, input logic [15:0] d, output logic [17:0] r);
        @(negedge ref_clk);
        pm_cmd   <= c;
        pm_page  <= p;
        pm_wdata <= d;
        pm_wr    <= w;
        pm_rd    <= ~w;
        @(negedge ref_clk);
        r = {pm_ack, pm_nack, pm_rdata};
        pm_wr    <= 1'b0;
        pm_rd    <= 1'b0;
        pm_cmd   <= ~c;
        pm_wdata <= ~d;
    endtask
endmodule

// file: vuvrs_l11.sv
`timescale 1ns/10ps
module vuvrs_l11
    import vuvrs_pkg::*;
(
    vuvrs_l11_if.dec bus
);

    logic signed [5:0] sh;
    logic [47:0]       wide;
    logic [47:0]       scaled;

    // ------------------------------------------------------------
    // Milliseconds word to ticks, negative values read as zero
    // ------------------------------------------------------------
    always_comb begin
        sh   = $signed({bus.word[EXP_MSB], bus.word[EXP_MSB:EXP_LSB]})
             + $signed(6'(TICK_SHIFT));
        wide = bus.word[MANT_MSB] ? 48'h0
             : {37'h0, bus.word[MANT_MSB:0]};
        if (sh >= 0) begin
            scaled = wide << sh[4:0];
        end else begin
            scaled = wide >> 5'(-sh);
        end
        bus.ticks = (|scaled[47:TICK_W]) ? {TICK_W{1'b1}}
                  : scaled[TICK_W-1:0];
    end

endmodule

// file: vuvrs_l11_if.sv
`timescale 1ns/10ps
interface vuvrs_l11_if;
    import vuvrs_pkg::*;
    logic [15:0]       word;
    logic [TICK_W-1:0] ticks;
    modport src (output word, input ticks);
    modport dec (input word, output ticks);
endinterface

// file: vuvrs_pkg.sv
package vuvrs_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ         = 200_000_000;
    localparam int MS_PER_S       = 1000;
    localparam int TICK_PER_MS    = 16;
    localparam int TICK_SHIFT     = 4;
    localparam int TICK_CYC_DFLT  = CLK_HZ / (MS_PER_S * TICK_PER_MS);
    localparam int RETRY_UNIT_MS  = 35;
    localparam int DLY_MIN_MS     = 2;
    localparam int DLY_MAX_MS     = 5000;
    localparam int RISE_MAX_MS    = 100;
    localparam int TICK_W         = 20;
    localparam int RETRY_W        = 13;
    localparam int DIV_W          = 16;

    localparam logic [RETRY_W-1:0] RETRY_UNIT_TICKS =
        RETRY_W'(RETRY_UNIT_MS * TICK_PER_MS);
    localparam logic [TICK_W-1:0] DLY_MIN_TICKS =
        TICK_W'(DLY_MIN_MS * TICK_PER_MS);
    localparam logic [TICK_W-1:0] DLY_MAX_TICKS =
        TICK_W'(DLY_MAX_MS * TICK_PER_MS);
    localparam logic [TICK_W-1:0] RISE_MAX_TICKS =
        TICK_W'(RISE_MAX_MS * TICK_PER_MS);

    // ------------------------------------------------------------
    // Command codes and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0]  CMD_UV_RESP      = 8'h5A;
    localparam logic [7:0]  CMD_PG_ON        = 8'h5E;
    localparam logic [7:0]  CMD_TURN_ON_DELAY    = 8'h60;
    localparam logic [7:0]  CMD_TURN_ON_RISE_TIME     = 8'h61;
    localparam logic [7:0]  UV_RESP_RST      = 8'hBF;
    localparam logic [15:0] TURN_ON_DELAY_RST0   = 16'hD280;
    localparam logic [15:0] TURN_ON_DELAY_RST1   = 16'hCA80;
    localparam logic [15:0] TURN_ON_RISE_TIME_RST     = 16'hCA80;
    localparam logic [15:0] PG_ON_RST        = 16'h0000;
    localparam logic [19:0] PG_NUM           = 20'h00009;
    localparam logic [19:0] PG_DEN           = 20'h0000A;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int RESP_MSB  = 7;
    localparam int RESP_LSB  = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int RDLY_MSB  = 2;
    localparam int RDLY_LSB  = 0;
    localparam int EXP_MSB   = 15;
    localparam int EXP_LSB   = 11;
    localparam int MANT_MSB  = 10;

    localparam logic [1:0] RESP_RETRY = 2'h2;
    localparam logic [1:0] RESP_HOLD  = 2'h3;
    localparam logic [2:0] RETRY_CONT = 3'h7;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_DELAY,
        ST_RISE,
        ST_ON,
        ST_HOLD,
        ST_RETRY,
        ST_LATCH
    } vuvrs_state_e;

endpackage

// file: vuvrs_top.sv
`timescale 1ns/10ps
// Operation
// - Response 10: disable output on fault, restart per retry field.
// - Response 11: output off while fault persists, then re-enabled.
// - Fault pulls alert low, sets sticky flag; only clear-faults clears.
// - Retry 000 and unused codes: no restart until re-enabled.
// - Retry 111: restart repeatedly until disabled or other fault.
// - Restart attempt starts spaced (code+1) times 35 ms.
// - Undervoltage response byte resets to BFh.
// - Power-good sets above on-threshold, clears below UV fault limit.
// - Power-good threshold is paged word, default 0.9 times strap.
// - Wait turn-on delay, 2 ms to 5 s, before output rises.
// - Turn-on delay resets D280h page 0, CA80h page 1.
// - Ramp over rise time; multi-phase skips the ramp, output goes straight on.
// - Rise time accepted 0 to 100 ms.
// - Rise time word resets to CA80h.
module vuvrs_top
    import vuvrs_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC_DFLT
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  pm_cmd,
    input  wire logic        pm_page,
    input  wire logic        pm_wr,
    input  wire logic        pm_rd,
    input  wire logic [15:0] pm_wdata,
    output logic      [15:0] pm_rdata,
    output logic             pm_ack,
    output logic             pm_nack,
    input  wire logic        en_pin,
    input  wire logic        operation_on,
    input  wire logic        vin_uv_fault,
    input  wire logic        other_fault,
    input  wire logic        multi_phase,
    input  wire logic [15:0] output_setpoint_strap,
    input  wire logic [15:0] vout_meas,
    input  wire logic [15:0] output_undervoltage_fault_threshold,
    output logic             out_enable,
    output logic             ramp_active,
    output logic             power_good,
    output logic             alert_out_n,
    output logic             uv_fault_flag
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_pipe_ff;
    logic       rst_sync_n;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_ff <= 2'b00;
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe_ff[1];

    // ------------------------------------------------------------
    // Configuration words
    // ------------------------------------------------------------
    logic [7:0]  uv_resp_ff;
    logic [15:0] pg_on_ff        [2];
    logic [15:0] turn_on_delay_ff [2];
    logic [15:0] rise_time_ff    [2];
    logic        strap_done_ff;
    logic [19:0] pg_prod;
    logic [15:0] pg_default;
    logic        clr_cmd;

    assign pg_prod    = {4'h0, output_setpoint_strap} * PG_NUM;
    assign pg_default = 16'(pg_prod / PG_DEN);
    assign clr_cmd    = pm_wr && (pm_cmd == CMD_CLEAR_FAULTS);

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            uv_resp_ff          <= UV_RESP_RST;
            turn_on_delay_ff[0] <= TURN_ON_DELAY_RST0;
            turn_on_delay_ff[1] <= TURN_ON_DELAY_RST1;
            rise_time_ff[0]     <= TURN_ON_RISE_TIME_RST;
            rise_time_ff[1]     <= TURN_ON_RISE_TIME_RST;
            pg_on_ff[0]         <= PG_ON_RST;
            pg_on_ff[1]         <= PG_ON_RST;
            strap_done_ff       <= 1'b0;
        end else begin
            if (!strap_done_ff) begin
                pg_on_ff[0]   <= pg_default;
                pg_on_ff[1]   <= pg_default;
                strap_done_ff <= 1'b1;
            end
            if (pm_wr) begin
                case (pm_cmd)
                    CMD_UV_RESP:   uv_resp_ff <= pm_wdata[7:0];
                    CMD_PG_ON:     pg_on_ff[pm_page] <= pm_wdata;
                    CMD_TURN_ON_DELAY: turn_on_delay_ff[pm_page] <= pm_wdata;
                    CMD_TURN_ON_RISE_TIME:  rise_time_ff[pm_page] <= pm_wdata;
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Command port answer
    // ------------------------------------------------------------
    logic [15:0] pm_rdata_ff;
    logic        pm_ack_ff;
    logic        pm_nack_ff;

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pm_rdata_ff <= 16'h0000;
            pm_ack_ff   <= 1'b0;
            pm_nack_ff  <= 1'b0;
        end else begin
            pm_ack_ff  <= 1'b0;
            pm_nack_ff <= 1'b0;
            if (pm_wr || pm_rd) begin
                pm_ack_ff <= 1'b1;
                case (pm_cmd)
                    CMD_UV_RESP:   pm_rdata_ff <= {8'h00, uv_resp_ff};
                    CMD_PG_ON:     pm_rdata_ff <= pg_on_ff[pm_page];
                    CMD_TURN_ON_DELAY: pm_rdata_ff <= turn_on_delay_ff[pm_page];
                    CMD_TURN_ON_RISE_TIME:  pm_rdata_ff <= rise_time_ff[pm_page];
                    CMD_CLEAR_FAULTS: begin
                        pm_rdata_ff <= 16'h0000;
                        pm_ack_ff   <= pm_wr;
                        pm_nack_ff  <= pm_rd;
                    end
                    default: begin
                        pm_rdata_ff <= 16'h0000;
                        pm_ack_ff   <= 1'b0;
                        pm_nack_ff  <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Delay and rise decode (page 0 drives the output)
    // ------------------------------------------------------------
    vuvrs_l11_if dly_if ();
    vuvrs_l11_if rise_if ();
    logic [TICK_W-1:0] delay_t;
    logic [TICK_W-1:0] rise_t;

    assign dly_if.word  = turn_on_delay_ff[0];
    assign rise_if.word = rise_time_ff[0];

    vuvrs_l11 u_dly_dec (
        .bus (dly_if)
    );
    vuvrs_l11 u_rise_dec (
        .bus (rise_if)
    );

    assign delay_t = (dly_if.ticks < DLY_MIN_TICKS) ? DLY_MIN_TICKS
                   : (dly_if.ticks > DLY_MAX_TICKS) ? DLY_MAX_TICKS
                   : dly_if.ticks;
    assign rise_t  = (rise_if.ticks > RISE_MAX_TICKS) ? RISE_MAX_TICKS
                   : rise_if.ticks;

    // ------------------------------------------------------------
    // Sixteenth-millisecond tick
    // ------------------------------------------------------------
    logic [DIV_W-1:0] div_ff;
    logic             tick_ff;

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (div_ff == DIV_W'(TICK_CYCLES - 1)) begin
            div_ff  <= '0;
            tick_ff <= 1'b1;
        end else begin
            div_ff  <= div_ff + DIV_W'(1);
            tick_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    vuvrs_state_e       state_ff;
    vuvrs_state_e       nxt_state;
    vuvrs_state_e       fault_dest;
    logic               enabled;
    logic               start_attempt;
    logic [TICK_W-1:0]  seq_cnt_ff;
    logic [RETRY_W-1:0] retry_cnt_ff;
    logic [RETRY_W-1:0] retry_target;
    logic               retry_done;
    logic               skip_rise;

    assign enabled      = en_pin && operation_on;
    assign retry_target = RETRY_W'((RETRY_W'(uv_resp_ff[RDLY_MSB:RDLY_LSB])
                        + RETRY_W'(1)) * RETRY_UNIT_TICKS);
    assign retry_done   = (retry_cnt_ff >= retry_target);
    assign skip_rise    = multi_phase || (rise_t == '0);

    always_comb begin
        if (uv_resp_ff[RESP_MSB:RESP_LSB] == RESP_HOLD) begin
            fault_dest = ST_HOLD;
        end else if (uv_resp_ff[RETRY_MSB:RETRY_LSB] == RETRY_CONT) begin
            fault_dest = ST_RETRY;
        end else begin
            fault_dest = ST_LATCH;
        end
    end

    always_comb begin
        nxt_state     = state_ff;
        start_attempt = 1'b0;
        if (!enabled) begin
            nxt_state = ST_OFF;
        end else if (other_fault) begin
            nxt_state = ST_LATCH;
        end else begin
            unique case (state_ff)
                ST_OFF: begin
                    nxt_state     = ST_DELAY;
                    start_attempt = 1'b1;
                end
                ST_DELAY: begin
                    if (vin_uv_fault) begin
                        nxt_state = fault_dest;
                    end else if (seq_cnt_ff >= delay_t) begin
                        nxt_state = skip_rise ? ST_ON : ST_RISE;
                    end
                end
                ST_RISE: begin
                    if (vin_uv_fault) begin
                        nxt_state = fault_dest;
                    end else if (seq_cnt_ff >= rise_t) begin
                        nxt_state = ST_ON;
                    end
                end
                ST_ON: begin
                    if (vin_uv_fault) begin
                        nxt_state = fault_dest;
                    end
                end
                ST_HOLD: begin
                    if (!vin_uv_fault) begin
                        nxt_state     = ST_DELAY;
                        start_attempt = 1'b1;
                    end
                end
                ST_RETRY: begin
                    if (retry_done) begin
                        nxt_state     = ST_DELAY;
                        start_attempt = 1'b1;
                    end
                end
                ST_LATCH: nxt_state = ST_LATCH;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_ff <= ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            seq_cnt_ff <= '0;
        end else if (nxt_state != state_ff) begin
            seq_cnt_ff <= '0;
        end else if (tick_ff) begin
            seq_cnt_ff <= seq_cnt_ff + TICK_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            retry_cnt_ff <= '0;
        end else if (start_attempt) begin
            retry_cnt_ff <= '0;
        end else if (tick_ff && !retry_done) begin
            retry_cnt_ff <= retry_cnt_ff + RETRY_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Output stage, power-good, fault flag
    // ------------------------------------------------------------
    logic out_en_ff;
    logic ramp_ff;
    logic pg_ff;
    logic uv_flag_ff;
    logic alert_n_ff;
    logic nxt_uv_flag;

    assign nxt_uv_flag = vin_uv_fault || (uv_flag_ff && !clr_cmd);

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            out_en_ff <= 1'b0;
            ramp_ff   <= 1'b0;
        end else begin
            out_en_ff <= (nxt_state == ST_RISE) || (nxt_state == ST_ON);
            ramp_ff   <= (nxt_state == ST_RISE);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pg_ff <= 1'b0;
        end else if (!out_en_ff) begin
            pg_ff <= 1'b0;
        end else if (vout_meas > pg_on_ff[0]) begin
            pg_ff <= 1'b1;
        end else if (vout_meas < output_undervoltage_fault_threshold) begin
            pg_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            uv_flag_ff <= 1'b0;
            alert_n_ff <= 1'b1;
        end else begin
            uv_flag_ff <= nxt_uv_flag;
            alert_n_ff <= !nxt_uv_flag;
        end
    end

    assign pm_rdata      = pm_rdata_ff;
    assign pm_ack        = pm_ack_ff;
    assign pm_nack       = pm_nack_ff;
    assign out_enable    = out_en_ff;
    assign ramp_active   = ramp_ff;
    assign power_good    = pg_ff;
    assign alert_out_n   = alert_n_ff;
    assign uv_fault_flag = uv_flag_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_n);

    sequence s_run_fault;
        enabled && !other_fault && vin_uv_fault
        && (state_ff == ST_ON || state_ff == ST_RISE);
    endsequence

    sequence s_no_retry_cfg;
        uv_resp_ff[RESP_MSB:RESP_LSB] == RESP_RETRY
        && uv_resp_ff[RETRY_MSB:RETRY_LSB] != RETRY_CONT;
    endsequence

    flag_set_a: assert property (vin_uv_fault |=> uv_flag_ff)
        else $error("fault flag not set");
    alert_follows_a: assert property (
        (vin_uv_fault || (!alert_n_ff && !clr_cmd)) |=> !alert_n_ff)
        else $error("alert released without clear");
    flag_sticky_a: assert property (
        uv_flag_ff && !clr_cmd |=> uv_flag_ff)
        else $error("fault flag dropped without clear");
    no_retry_a: assert property (
        s_run_fault ##0 s_no_retry_cfg |=> state_ff == ST_LATCH
        ##1 !out_en_ff)
        else $error("no-retry fault did not latch off");
    hold_resume_a: assert property (
        state_ff == ST_HOLD && enabled && !other_fault && !vin_uv_fault
        |=> state_ff == ST_DELAY)
        else $error("hold did not resume after fault");
    retry_wait_a: assert property (
        state_ff == ST_RETRY && enabled && !other_fault && !retry_done
        |=> state_ff == ST_RETRY && !out_en_ff)
        else $error("retry started before its delay");
    off_abandon_a: assert property (
        !enabled |=> state_ff == ST_OFF && !out_en_ff)
        else $error("disable did not stop the output");
    pg_drop_a: assert property (
        $fell(pg_ff) |-> !$past(out_en_ff)
        || $past(vout_meas) < $past(output_undervoltage_fault_threshold))
        else $error("power-good dropped inside hysteresis");
    delay_dark_a: assert property (
        state_ff == ST_DELAY |-> !out_en_ff && seq_cnt_ff <= delay_t)
        else $error("output on during turn-on delay");

endmodule
